// file: verif/mpfs_assertions.sv
/* Checker on the ports of mpfs_top.
   Assumes it is bound into mpfs_top by the testbench. */
`default_nettype none
module mpfs_assertions (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic [7:0] cfg_book,
  input wire logic [7:0] cfg_page,
  input wire logic [7:0] cfg_addr,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic       cfg_rvalid,
  input wire logic [2:0] pin_drive,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_ie,
  input wire logic [2:0] pin_to_mux
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Properties
  // ********************
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_reset_clears_pins: assert property ($past(srst) |-> pin_oe == 0 && pin_ie == 0)
    else $error("pins active after reset");
  a_ie_excl_oe: assert property ((pin_ie & pin_oe) == 0)
    else $error("input and output buffer both on");
  a_mux_needs_ie: assert property ((pin_to_mux & ~pin_ie) == 0)
    else $error("mux level without input buffer");
  a_drive_needs_oe: assert property ((pin_drive & ~pin_oe) == 0)
    else $error("drive level without enable");
  a_rvalid_after_rd: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
  a_rvalid_has_cause: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("answer without read");
  a_unmapped_reads_zero: assert property (cfg_rd && !(cfg_book == 0
    && cfg_page == 1 && cfg_addr >= 8'h44 && cfg_addr <= 8'h46) |=> cfg_rdata == 0)
    else $error("unmapped read not zero");
  a_oe_holds_idle: assert property (!cfg_wr [*2] |=> $stable(pin_oe) && $stable(pin_ie))
    else $error("pin role changed without write");
  c_read: cover property (cfg_rvalid);
  c_input: cover property (pin_ie != 0);
  c_drive: cover property (pin_oe != 0);
endmodule // mpfs_assertions
`default_nettype wire

// file: verif/mpfs_pin_partner.sv
/* Far side of the three pins: outside parts that drive a pin level.
   Assumes the design's output enable is high while it drives. */
`default_nettype none
module mpfs_pin_partner (
  // Design side of the pins
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pin_drive,
  // Level the outside part drives when the pin is free
  input  wire logic [2:0] ext_lvl,
  // Resolved wire level
  output wire logic [2:0] pin_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  // The outside part drives only where the device has let go
  assign pin_sense = (pin_oe & pin_drive) | (~pin_oe & ext_lvl);
endmodule // mpfs_pin_partner
`default_nettype wire

// file: verif/tb_top.sv
/* Testbench for mpfs_top: registers, pin role table, mid-run reset.
   Assumes verilog/ is on the include path. */
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: mismatch got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, srst, cfg_wr, cfg_rd;
  logic [7:0]  cfg_book, cfg_page, cfg_addr, cfg_wdata;
  logic [14:0] src;          // Routed sources, see index table in idx
  logic [2:0]  ext_lvl;      // Outside level per pin
  wire  [7:0]  cfg_rdata;
  wire         cfg_rvalid;
  wire  [2:0]  pin_sense, pin_drive, pin_oe, pin_ie, pin_to_mux;
  int          error_cnt, num_checks;
  mpfs_top i_dut (.mclk(mclk), .srst(srst), .cfg_book(cfg_book), .cfg_page(cfg_page),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .shared_bitbang_level(src[0]),
    .pdm_clock(src[1]), .reference_clock_output(src[2]), .interrupt_lines(src[6:3]),
    .serial_if_one_word_clock(src[7]), .serial_if_one_bit_clock(src[8]),
    .serial_if_one_data_out(src[9]), .serial_if_two_bit_clock(src[10]),
    .serial_if_two_data_out(src[11]), .merged_if_word_clock(src[12]),
    .merged_if_bit_clock(src[13]), .merged_if_data_out(src[14]), .pin_sense(pin_sense),
    .pin_drive(pin_drive), .pin_oe(pin_oe), .pin_ie(pin_ie), .pin_to_mux(pin_to_mux));
  mpfs_pin_partner i_far (.pin_oe(pin_oe), .pin_drive(pin_drive), .ext_lvl(ext_lvl),
    .pin_sense(pin_sense));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // ********************
  // Register port tasks
  // ********************
  // Strobes last one cycle; each task first lets an edge pass, so two
  // calls in a row never touch a strobe twice in one time step
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge mclk);
    #1 cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    @(posedge mclk);
    #1 cfg_wr = 1'h0;
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    @(posedge mclk);
    #1 cfg_addr = a;
    cfg_rd = 1'h1;
    @(posedge mclk);
    #1 cfg_rd = 1'h0;
    `CHK(cfg_rvalid, 1'b1)
    `CHK(cfg_rdata, e)
  endtask
  // Source index driven per selector: 15 static level, 30 input, 31 off
  function automatic int idx(int k, int s);
    case (s)
      1: return 30;
      3: return 15;
      4: return 0;
      5: return k == 2 ? 0 : 1;
      6: return k == 0 ? 1 : 2;
      7, 8, 9: return s - 4;
      10: return k == 0 ? 5 : 6;
      12, 17: return 7;
      13: return 8;
      16: return 9;
      18: return 10;
      21: return 11;
      27, 28, 29: return s - 15;
      default: return 31;
    endcase
  endfunction
  // ********************
  // Scenarios
  // ********************
  task t_regs;
    for (int k = 0; k < 3; k++) rd(8'h44 + k, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(8'h44 + k, 8'hA0 + k);
      rd(8'h44 + k, 8'hA0 + k);
    end
    wr(8'h47, 8'hFF);
    rd(8'h47, 8'h00);
    cfg_page = 8'h02;
    wr(8'h44, 8'h1F);
    rd(8'h44, 8'h00);
    cfg_page = 8'h01;
    rd(8'h44, 8'hA0);
    $display("test regs done");
  endtask
  // Five source patterns give every index its own code (index plus one)
  task t_table;
    int e;
    logic lvl;
    for (int k = 0; k < 3; k++) for (int s = 0; s < 32; s++) for (int j = 0; j < 5; j++) begin
      for (int i = 0; i < 15; i++) src[i] = ((i + 1) >> j) & 1;
      lvl = (j == 4);
      ext_lvl[k] = j[0];
      wr(8'h44 + k, {1'b1, lvl, 1'b1, s[4:0]});
      repeat (8) @(posedge mclk);
      #1 e = idx(k, s);
      `CHK(pin_oe[k], e < 16)
      `CHK(pin_ie[k], e == 30)
      `CHK(pin_drive[k], e < 15 ? src[e] : (e == 15 ? lvl : 1'h0))
      `CHK(pin_to_mux[k], e == 30 ? ext_lvl[k] : 1'h0)
    end
    $display("test table done");
  endtask
  task t_reset;
    wr(8'h46, 8'h04);
    repeat (2) @(posedge mclk);
    #1 `CHK(pin_oe, 3'h4)
    srst = 1'h1;
    repeat (2) @(posedge mclk);
    #1 srst = 1'h0;
    `CHK(pin_oe, 3'h0)
    `CHK({pin_drive, pin_ie, pin_to_mux}, 9'h000)
    rd(8'h46, 8'h00);
    $display("test reset done");
  endtask
  // ********************
  // Verdict
  // ********************
  task summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    summarize;
  end
  initial begin
    {srst, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_book} = 1'b1 << 26;
    cfg_page = 8'h01;
    src = 0;
    ext_lvl = 0;
    repeat (8) @(posedge mclk);
    #1 srst = 0;
    t_regs;
    t_table;
    t_reset;
    summarize;
  end
endmodule // tb_top
bind mpfs_top mpfs_assertions i_chk (.mclk(mclk), .srst(srst), .cfg_book(cfg_book),
  .cfg_page(cfg_page), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .pin_drive(pin_drive), .pin_oe(pin_oe),
  .pin_ie(pin_ie), .pin_to_mux(pin_to_mux));
`default_nettype wire

// file: verilog/mpfs_consts.vh
/*
  Constants for the multipurpose pin function select block: register
  page and offsets, field positions and selector codes.
  Assumes it is included once per file by its bare name.
*/
// Overview of operation
// - Selector 0 disables pin, both buffers off
// - Selector 1 passes pin level to input mux
// - Selector 3 drives static level bit 6
// - Selector 4 drives shared bit-bang level
// - Selector 5 on pins A, B: PDM clock
// - Selector 5 on pin C: bit-bang level
// - Selector 6: reference clock, PDM clock on A
// - Selectors 7-10 route interrupts, A repeats three
// - Selector 12 drives serial one word clock
// - Selector 13 drives serial one bit clock
// - Selectors 16-18, 21, 27-29 drive serial outputs
// - Registers at book 0, page 1, 0x44-0x46
// - Reset clears all register fields to zero
`ifndef MPFS_CONSTS_VH
`define MPFS_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define MPFS_BOOK          8'h00
`define MPFS_PAGE          8'h01
`define MPFS_OFS_PIN_A     8'h44
`define MPFS_OFS_PIN_B     8'h45
`define MPFS_OFS_PIN_C     8'h46
`define MPFS_REG_RESET     8'h00

// ****************************************
// Field positions
// ****************************************
`define MPFS_SEL_MSB       4
`define MPFS_SEL_LSB       0
`define MPFS_LEVEL_BIT     6

// ****************************************
// Selector codes
// ****************************************
`define MPFS_SEL_OFF       5'h00
`define MPFS_SEL_INPUT     5'h01
`define MPFS_SEL_STATIC    5'h03
`define MPFS_SEL_BITBANG   5'h04
`define MPFS_SEL_PDM_BB    5'h05
`define MPFS_SEL_REFCLK    5'h06
`define MPFS_SEL_IRQ1      5'h07
`define MPFS_SEL_IRQ2      5'h08
`define MPFS_SEL_IRQ3      5'h09
`define MPFS_SEL_IRQ4      5'h0A
`define MPFS_SEL_S1_WCLK   5'h0C
`define MPFS_SEL_S1_BCLK   5'h0D
`define MPFS_SEL_S1_DOUT   5'h10
`define MPFS_SEL_S1_WCLK2  5'h11
`define MPFS_SEL_S2_BCLK   5'h12
`define MPFS_SEL_S2_DOUT   5'h15
`define MPFS_SEL_M_WCLK    5'h1B
`define MPFS_SEL_M_BCLK    5'h1C
`define MPFS_SEL_M_DOUT    5'h1D

// ****************************************
// Pin flavours for the per-pin mux
// ****************************************
`define MPFS_KIND_A        2'h0
`define MPFS_KIND_B        2'h1
`define MPFS_KIND_C        2'h2

`endif

// file: verilog/mpfs_pin_mux.v
/*
  One pin's function mux: from its config byte decides output enable,
  output level, input-buffer enable and the input value to the mux.
  Assumes routed signals are already on mclk and that the pin input
  has been synchronised by the caller.
*/
`default_nettype none
`include "mpfs_consts.vh"

module mpfs_pin_mux #(
  parameter [1:0] KIND = `MPFS_KIND_A   // Which pin table applies
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       srst,
  // Configuration
  input  wire [7:0] cfg,
  // Routed sources
  input  wire       shared_bitbang_level,
  input  wire       pdm_clock,
  input  wire       reference_clock_output,
  input  wire [3:0] interrupt_lines,
  input  wire       serial_if_one_word_clock,
  input  wire       serial_if_one_bit_clock,
  input  wire       serial_if_one_data_out,
  input  wire       serial_if_two_bit_clock,
  input  wire       serial_if_two_data_out,
  input  wire       merged_if_word_clock,
  input  wire       merged_if_bit_clock,
  input  wire       merged_if_data_out,
  // Pin side
  input  wire       pin_sync,
  output reg        pin_drive,
  output reg        pin_oe,
  output reg        pin_ie,
  output reg        pin_to_mux
);

  wire [4:0] sel;          // Function selector field
  wire       level;        // Static level bit
  reg        drv_next;     // Next output level
  reg        oe_next;      // Next output enable

  // Bits 7 and 5 are never looked at here
  assign sel   = cfg[`MPFS_SEL_MSB:`MPFS_SEL_LSB];
  assign level = cfg[`MPFS_LEVEL_BIT];

  // ****************************************
  // Selector decode
  // ****************************************
  // Default is off, so every reserved code leaves buffers down
  always @* begin
    drv_next = 1'h0;
    oe_next  = 1'h1;
    case (sel)
      `MPFS_SEL_STATIC:   drv_next = level;
      `MPFS_SEL_BITBANG:  drv_next = shared_bitbang_level;
      `MPFS_SEL_PDM_BB: begin
        // Pin C lists this as bit-bang, others as PDM clock
        if (KIND == `MPFS_KIND_C) begin
          drv_next = shared_bitbang_level;
        end else begin
          drv_next = pdm_clock;
        end
      end
      `MPFS_SEL_REFCLK: begin
        if (KIND == `MPFS_KIND_A) begin
          drv_next = pdm_clock;
        end else begin
          drv_next = reference_clock_output;
        end
      end
      `MPFS_SEL_IRQ1:     drv_next = interrupt_lines[0];
      `MPFS_SEL_IRQ2:     drv_next = interrupt_lines[1];
      `MPFS_SEL_IRQ3:     drv_next = interrupt_lines[2];
      `MPFS_SEL_IRQ4: begin
        // Pin A's table repeats interrupt three here
        if (KIND == `MPFS_KIND_A) begin
          drv_next = interrupt_lines[2];
        end else begin
          drv_next = interrupt_lines[3];
        end
      end
      `MPFS_SEL_S1_WCLK:  drv_next = serial_if_one_word_clock;
      `MPFS_SEL_S1_BCLK:  drv_next = serial_if_one_bit_clock;
      `MPFS_SEL_S1_DOUT:  drv_next = serial_if_one_data_out;
      `MPFS_SEL_S1_WCLK2: drv_next = serial_if_one_word_clock;
      `MPFS_SEL_S2_BCLK:  drv_next = serial_if_two_bit_clock;
      `MPFS_SEL_S2_DOUT:  drv_next = serial_if_two_data_out;
      `MPFS_SEL_M_WCLK:   drv_next = merged_if_word_clock;
      `MPFS_SEL_M_BCLK:   drv_next = merged_if_bit_clock;
      `MPFS_SEL_M_DOUT:   drv_next = merged_if_data_out;
      default:            oe_next  = 1'h0;
    endcase
  end

  // ****************************************
  // Registered pin outputs
  // ****************************************
  // Registered for glitch-free pins; costs one cycle of latency
  always @(posedge mclk) begin
    if (srst) begin
      pin_drive  <= 1'h0;
      pin_oe     <= 1'h0;
      pin_ie     <= 1'h0;
      pin_to_mux <= 1'h0;
    end else begin
      pin_drive  <= drv_next & oe_next;
      pin_oe     <= oe_next;
      pin_ie     <= (sel == `MPFS_SEL_INPUT);
      // Input mux sees zero while the input buffer is off
      pin_to_mux <= (sel == `MPFS_SEL_INPUT) & pin_sync;
    end
  end

endmodule // mpfs_pin_mux
`default_nettype wire

// file: verilog/mpfs_top.v
/*
  Multipurpose pin function select: three config registers on the
  device's book/page register port and three pin muxes.
  Assumes the register port is a simple strobe interface on mclk,
  with book and page already decoded upstream into cfg_book/cfg_page.
*/
`default_nettype none
`include "mpfs_consts.vh"

module mpfs_top (
  // Clock and reset
  input  wire       mclk,
  input  wire       srst,
  // Register port
  input  wire [7:0] cfg_book,
  input  wire [7:0] cfg_page,
  input  wire [7:0] cfg_addr,
  input  wire       cfg_wr,
  input  wire       cfg_rd,
  input  wire [7:0] cfg_wdata,
  output reg  [7:0] cfg_rdata,
  output reg        cfg_rvalid,
  // Routed sources
  input  wire       shared_bitbang_level,
  input  wire       pdm_clock,
  input  wire       reference_clock_output,
  input  wire [3:0] interrupt_lines,
  input  wire       serial_if_one_word_clock,
  input  wire       serial_if_one_bit_clock,
  input  wire       serial_if_one_data_out,
  input  wire       serial_if_two_bit_clock,
  input  wire       serial_if_two_data_out,
  input  wire       merged_if_word_clock,
  input  wire       merged_if_bit_clock,
  input  wire       merged_if_data_out,
  // Pins: index 0 audio data in, 1 link clock, 2 link data out
  input  wire [2:0] pin_sense,
  output wire [2:0] pin_drive,
  output wire [2:0] pin_oe,
  output wire [2:0] pin_ie,
  output wire [2:0] pin_to_mux
);

  reg  [7:0] data_in_pin_config_reg;            // Pin A config
  reg  [7:0] chip_link_clock_pin_config_reg;    // Pin B config
  reg  [7:0] chip_link_dataout_pin_config_reg;  // Pin C config
  reg  [2:0] sync1_reg;                         // Synchroniser stage 1
  reg  [2:0] sync2_reg;                         // Synchroniser stage 2
  reg  [2:0] sync3_reg;                         // Synchroniser stage 3
  reg  [2:0] pin_in_reg;                        // Accepted pin level
  wire       page_hit;                          // Book and page match
  wire [7:0] cfg_bus [0:2];                     // Configs by pin index
  reg  [7:0] rd_word_next;                      // Byte the next read returns

  // ****************************************
  // Limitations
  // ****************************************
  // No high-Z or bus-keeper control lives here: a pin whose enable is
  // low is simply not driven by this block, and what the pad does then
  // is the pad's business.
  // The other general-purpose pins and the input-pin modes sit
  // elsewhere; only the three pins of this block are decoded.

  // ****************************************
  // Pin role summary
  // ****************************************
  // Each config byte holds a 5-bit selector in bits 4..0 and a static
  // level in bit 6; bits 7 and 5 are plain storage.
  //   Selector  Role on the pin
  //   0         Off: both pin buffers switched off
  //   1         Input: level goes on to the internal input mux
  //   3         Output: static level taken from bit 6
  //   4         Output: shared bit-bang level
  //   5         Output: PDM clock on pins A and B, bit-bang on pin C
  //   6         Output: PDM clock on pin A, reference clock elsewhere
  //   7..9      Output: interrupt lines one to three
  //   10        Output: interrupt four, but line three on pin A
  //   12, 13    Output: serial one word clock, bit clock
  //   16, 17    Output: serial one data out, word clock
  //   18, 21    Output: serial two bit clock, data out
  //   27..29    Output: merged word clock, bit clock, data out
  //   others    Reserved: handled like 0, buffers stay off
  // Clock-like sources pass one flip-flop on mclk, so the pin copy is
  // only as clean as mclk allows; a source that toggles near the mclk
  // rate is better routed around this block.

  // ****************************************
  // Register decode
  // ****************************************
  assign page_hit = (cfg_book == `MPFS_BOOK) && (cfg_page == `MPFS_PAGE);
  assign cfg_bus[0] = data_in_pin_config_reg;
  assign cfg_bus[1] = chip_link_clock_pin_config_reg;
  assign cfg_bus[2] = chip_link_dataout_pin_config_reg;

  // Register port timing, as the host sees it:
  //   edge 0  write strobe sampled, byte stored at this edge
  //   edge 1  pin mux sees the new byte and registers its outputs
  //   after edge 1 the pin shows its new role
  // A read strobe at edge 0 gives cfg_rvalid and cfg_rdata after that
  // edge for one cycle. A write and a read of one byte at the same
  // edge read the old value, since the read samples the store first.
  // Writes store all eight bits, reserved ones too
  always @(posedge mclk) begin
    if (srst) begin
      data_in_pin_config_reg           <= `MPFS_REG_RESET;
      chip_link_clock_pin_config_reg   <= `MPFS_REG_RESET;
      chip_link_dataout_pin_config_reg <= `MPFS_REG_RESET;
    end else if (cfg_wr && page_hit) begin
      if (cfg_addr == `MPFS_OFS_PIN_A) begin
        data_in_pin_config_reg <= cfg_wdata;
      end
      if (cfg_addr == `MPFS_OFS_PIN_B) begin
        chip_link_clock_pin_config_reg <= cfg_wdata;
      end
      if (cfg_addr == `MPFS_OFS_PIN_C) begin
        chip_link_dataout_pin_config_reg <= cfg_wdata;
      end
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  // Address decode for reads; anything off this page reads zero
  always @* begin
    rd_word_next = `MPFS_REG_RESET;
    if (page_hit) begin
      case (cfg_addr)
        `MPFS_OFS_PIN_A: begin
          rd_word_next = data_in_pin_config_reg;
        end
        `MPFS_OFS_PIN_B: begin
          rd_word_next = chip_link_clock_pin_config_reg;
        end
        `MPFS_OFS_PIN_C: begin
          rd_word_next = chip_link_dataout_pin_config_reg;
        end
        default: begin
          // Unmapped byte on this page
          rd_word_next = `MPFS_REG_RESET;
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; zero while no read is under
  // way, so a stale byte never lingers on the read bus
  always @(posedge mclk) begin
    if (srst) begin
      cfg_rdata  <= `MPFS_REG_RESET;
      cfg_rvalid <= 1'h0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rd_word_next;
      end else begin
        cfg_rdata <= `MPFS_REG_RESET;
      end
    end
  end

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  // Three stages; a change counts once stages two and three agree.
  // Stage one may go metastable, so only stage two reads it. The
  // accepted level holds while stages two and three disagree, which
  // also rejects a one-cycle glitch that slips past stage one.
  // Cost: an input change reaches pin_to_mux five edges later.
  always @(posedge mclk) begin
    if (srst) begin
      sync1_reg  <= 3'h0;
      sync2_reg  <= 3'h0;
      sync3_reg  <= 3'h0;
      pin_in_reg <= 3'h0;
    end else begin
      sync1_reg  <= pin_sense;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      pin_in_reg <= (sync2_reg & sync3_reg) | (pin_in_reg & (sync2_reg | sync3_reg));
    end
  end

  // ****************************************
  // Per-pin function muxes
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      // Pin index picks which role table the mux applies
      localparam [1:0] PIN_KIND = (g == 0) ? `MPFS_KIND_A :
                                  (g == 1) ? `MPFS_KIND_B : `MPFS_KIND_C;
      mpfs_pin_mux #(
        .KIND(PIN_KIND)
      ) u_mux (
        .mclk                     (mclk),
        .srst                     (srst),
        .cfg                      (cfg_bus[g]),
        .shared_bitbang_level     (shared_bitbang_level),
        .pdm_clock                (pdm_clock),
        .reference_clock_output   (reference_clock_output),
        .interrupt_lines          (interrupt_lines),
        .serial_if_one_word_clock (serial_if_one_word_clock),
        .serial_if_one_bit_clock  (serial_if_one_bit_clock),
        .serial_if_one_data_out   (serial_if_one_data_out),
        .serial_if_two_bit_clock  (serial_if_two_bit_clock),
        .serial_if_two_data_out   (serial_if_two_data_out),
        .merged_if_word_clock     (merged_if_word_clock),
        .merged_if_bit_clock      (merged_if_bit_clock),
        .merged_if_data_out       (merged_if_data_out),
        .pin_sync                 (pin_in_reg[g]),
        .pin_drive                (pin_drive[g]),
        .pin_oe                   (pin_oe[g]),
        .pin_ie                   (pin_ie[g]),
        .pin_to_mux               (pin_to_mux[g])
      );
    end
  endgenerate

endmodule // mpfs_top
`default_nettype wire
